// ===== rtl/act_pkg.sv
// Functional notes
// R1: gain trim codes 0..15 map to -0.8 dB .. +0.7 dB, 0.1 dB per code.
// R2: gain trim resets to code 8, meaning zero dB on channel four.
// R3: gain trim low nibble is reserved; software writes zeros, reads return zeros.
// R4: channel four delayed by phase trim code modulator cycles, 0 to 255.
// R5: volume lock clear allows volume changes while powered; set blocks them.
// R6: software should set volume lock at 384 kHz and above, multichannel.
// R7: software keeps reserved dsp bit 6 at zero when writing.
// R8: decimation response 0 linear, 1 low latency, 2 ultra-low, 3 reserved.
// R9: summation code 1 outputs average of channels one and two; 0 disables.
// R10: highpass select 0 picks programmable first-order recursive all-pass default.
// R11: highpass codes 1, 2, 3 give cutoffs 0.00025, 0.002, 0.008 fs.
// R12: highpass select resets to code 1, the lowest fixed cutoff.
// R13: read/write fields read back last written value or reset value.
package act_pkg;
  localparam logic [7:0] ACT_OFS_GAIN_TRIM  = 8'h4E;
  localparam logic [7:0] ACT_OFS_PHASE_TRIM = 8'h4F;
  localparam logic [7:0] ACT_OFS_DSP_FIRST  = 8'h6B;

  localparam logic [7:0] ACT_RST_GAIN_TRIM  = 8'h80;
  localparam logic [7:0] ACT_RST_PHASE_TRIM = 8'h00;
  localparam logic [7:0] ACT_RST_DSP_FIRST  = 8'h01;

  localparam int ACT_POS_GAIN_TRIM    = 4;
  localparam int ACT_POS_VOLUME_LOCK  = 7;
  localparam int ACT_POS_DSP_RESERVED = 6;
  localparam int ACT_POS_DECIMATION   = 4;
  localparam int ACT_POS_SUMMATION    = 2;
  localparam int ACT_POS_HIGHPASS     = 0;

  localparam logic [4:0] ACT_GAIN_ZERO_CODE = 5'h08;
  localparam logic [1:0] ACT_SUM_AVERAGE    = 2'h1;
  localparam logic [1:0] ACT_HPF_PROGRAM    = 2'h0;

  typedef enum logic [1:0] {
    ACT_DECI_LINEAR    = 2'b00,
    ACT_DECI_LOW_LAT   = 2'b01,
    ACT_DECI_ULTRA_LOW = 2'b10,
    ACT_DECI_RESERVED  = 2'b11
  } act_deci_t;

  typedef struct packed {
    logic      volume_runtime_lock;
    logic      reserved_bit;
    act_deci_t decimation_response_select;
    logic [1:0] channel_summation_select;
    logic [1:0] highpass_select;
  } act_dsp_t;
endpackage

// ===== rtl/act_phase_delay.sv
`timescale 1ns/100ps
module act_phase_delay
  import act_pkg::*;
#(
  parameter int DEPTH = 256
)(
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_bit,
  input  wire logic [7:0] i_delay,
  output logic            o_bit
);
  logic [DEPTH-1:0] line;
  logic [DEPTH-1:0] next_line;
  logic             next_out;

  always_comb
  begin
    next_line = {line[DEPTH-2:0], i_bit};
    // code 0 passes straight, code n taps n cycles back
    if (i_delay == 8'h00)
    begin
      next_out = i_bit;
    end
    else
    begin
      next_out = line[i_delay - 8'h01]; // [R4]
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      line  <= '0;
      o_bit <= 1'b0;
    end
    else
    begin
      line  <= next_line;
      o_bit <= next_out;
    end
  end
endmodule

// ===== rtl/act_config.sv
`timescale 1ns/100ps
module act_config
  import act_pkg::*;
#(
  parameter int SAMPLE_W = 24
)(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_resetn,
  input  wire logic [7:0]                 i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [7:0]                 o_rdata,
  output logic                            o_rd_valid,
  input  wire logic                       i_adc_powered,
  input  wire logic                       i_volume_wr,
  input  wire logic [7:0]                 i_volume_value,
  output logic      [7:0]                 o_digital_volume,
  output logic      [3:0]                 o_fourth_channel_gain_trim,
  output logic signed [4:0]               o_gain_trim_steps,
  output logic      [7:0]                 o_fourth_channel_phase_trim,
  input  wire logic                       i_ch4_bit,
  output logic                            o_ch4_bit,
  output act_dsp_t                        o_dsp,
  output logic                            o_hpf_programmable,
  input  wire logic signed [SAMPLE_W-1:0] i_first_channel,
  input  wire logic signed [SAMPLE_W-1:0] i_second_channel,
  output logic signed [SAMPLE_W-1:0]      o_sum_sample
);
  logic [3:0]                 gain_trim;
  logic [7:0]                 phase_trim;
  act_dsp_t                   dsp;
  logic [3:0]                 next_gain_trim;
  logic [7:0]                 next_phase_trim;
  act_dsp_t                   next_dsp;
  logic [7:0]                 next_rdata;
  logic [7:0]                 next_volume;
  logic signed [4:0]          next_steps;
  logic                       next_hpf_prog;
  logic signed [SAMPLE_W:0]   pair_sum;
  logic signed [SAMPLE_W-1:0] next_sum;

  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [3:0] g,
                                          input logic [7:0] p, input act_dsp_t d);
    case (addr)
      ACT_OFS_GAIN_TRIM:  read_reg = {g, 4'h0}; // [R3]
      ACT_OFS_PHASE_TRIM: read_reg = p;
      ACT_OFS_DSP_FIRST:  read_reg = d;
      default:            read_reg = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    next_gain_trim  = gain_trim;
    next_phase_trim = phase_trim;
    next_dsp        = dsp;
    if (i_wr)
    begin
      case (i_addr)
        ACT_OFS_GAIN_TRIM:  next_gain_trim = i_wdata[ACT_POS_GAIN_TRIM +: 4]; // [R13]
        ACT_OFS_PHASE_TRIM: next_phase_trim = i_wdata; // [R13]
        ACT_OFS_DSP_FIRST:  next_dsp = act_dsp_t'(i_wdata); // [R13]
        default:            next_dsp = dsp;
      endcase
    end
    next_rdata = read_reg(i_addr, gain_trim, phase_trim, dsp);
    // code minus eight gives tenths of a dB
    next_steps = signed'({1'b0, next_gain_trim}) - signed'(ACT_GAIN_ZERO_CODE); // [R1]
    next_hpf_prog = (next_dsp.highpass_select == ACT_HPF_PROGRAM); // [R10] [R11]
    next_volume = o_digital_volume;
    if (i_volume_wr && !(dsp.volume_runtime_lock && i_adc_powered))
    begin
      next_volume = i_volume_value; // [R5]
    end
    pair_sum = (SAMPLE_W+1)'(i_first_channel) + (SAMPLE_W+1)'(i_second_channel);
    if (dsp.channel_summation_select == ACT_SUM_AVERAGE)
    begin
      next_sum = pair_sum[SAMPLE_W:1]; // [R9]
    end
    else
    begin
      next_sum = i_first_channel;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      gain_trim                   <= ACT_RST_GAIN_TRIM[7:4]; // [R2]
      phase_trim                  <= ACT_RST_PHASE_TRIM;
      dsp                         <= act_dsp_t'(ACT_RST_DSP_FIRST); // [R12] [R8]
      o_rdata                     <= 8'h00;
      o_rd_valid                  <= 1'b0;
      o_digital_volume            <= 8'h00;
      o_fourth_channel_gain_trim  <= ACT_RST_GAIN_TRIM[7:4];
      o_gain_trim_steps           <= 5'sh00;
      o_fourth_channel_phase_trim <= ACT_RST_PHASE_TRIM;
      o_dsp                       <= act_dsp_t'(ACT_RST_DSP_FIRST);
      o_hpf_programmable          <= 1'b0;
      o_sum_sample                <= '0;
    end
    else
    begin
      gain_trim                   <= next_gain_trim;
      phase_trim                  <= next_phase_trim;
      dsp                         <= next_dsp;
      o_rdata                     <= i_rd ? next_rdata : 8'h00;
      o_rd_valid                  <= i_rd;
      o_digital_volume            <= next_volume;
      o_fourth_channel_gain_trim  <= next_gain_trim;
      o_gain_trim_steps           <= next_steps;
      o_fourth_channel_phase_trim <= next_phase_trim;
      o_dsp                       <= next_dsp; // [R8]
      o_hpf_programmable          <= next_hpf_prog;
      o_sum_sample                <= next_sum;
    end
  end

  act_phase_delay #(
    .DEPTH (256)
  ) u_delay (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_bit     (i_ch4_bit),
    .i_delay   (phase_trim),
    .o_bit     (o_ch4_bit)
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  gain_reset_a: assert property ($rose(i_resetn) |-> o_gain_trim_steps == 5'sh00) // [R2]
    else $error("gain trim not zero dB after reset");
  gain_map_a: assert property (o_gain_trim_steps ==
      signed'({1'b0, o_fourth_channel_gain_trim}) - 5'sh08) // [R1]
    else $error("gain trim step mapping wrong");
  reserved_zero_a: assert property (o_rd_valid && $past(i_addr) == ACT_OFS_GAIN_TRIM
      |-> o_rdata[3:0] == 4'h0) // [R3]
    else $error("reserved nibble read nonzero");
  readback_a: assert property (i_wr && i_addr == ACT_OFS_PHASE_TRIM ##1
      (!i_wr && i_rd && i_addr == ACT_OFS_PHASE_TRIM) |=> o_rdata == $past(i_wdata, 2)) // [R13]
    else $error("phase trim readback mismatch");
  volume_lock_a: assert property (i_volume_wr && dsp.volume_runtime_lock && i_adc_powered
      |=> $stable(o_digital_volume)) // [R5]
    else $error("volume changed while locked");
  volume_take_a: assert property (i_volume_wr && !dsp.volume_runtime_lock
      |=> o_digital_volume == $past(i_volume_value)) // [R5]
    else $error("volume change not applied");
  hpf_reset_a: assert property ($rose(i_resetn) |-> o_dsp.highpass_select == 2'h1) // [R12]
    else $error("highpass reset code wrong");
  hpf_prog_a: assert property (o_hpf_programmable == (o_dsp.highpass_select == 2'h0)) // [R10]
    else $error("programmable highpass flag wrong");
  phase_zero_a: assert property (phase_trim == 8'h00 ##1 phase_trim == 8'h00
      |-> o_ch4_bit == $past(i_ch4_bit)) // [R4]
    else $error("zero phase trim delays");
  phase_one_a: assert property (phase_trim == 8'h01 [*3]
      |-> o_ch4_bit == $past(i_ch4_bit, 2)) // [R4]
    else $error("phase trim one cycle wrong");
  sum_avg_a: assert property (dsp.channel_summation_select == 2'h1 |=>
      o_sum_sample == SAMPLE_W'(($past({i_first_channel[SAMPLE_W-1], i_first_channel})
      + $past({i_second_channel[SAMPLE_W-1], i_second_channel})) >> 1)) // [R9]
    else $error("summation average wrong");

  sum_on_c: cover property (dsp.channel_summation_select == 2'h1);
  lock_block_c: cover property (i_volume_wr && dsp.volume_runtime_lock && i_adc_powered);
  max_delay_c: cover property (phase_trim == 8'hFF);
endmodule

// ===== tb/test_adc_channel_trim_dsp_config.sv
`timescale 1ns/100ps
module test_adc_channel_trim_dsp_config
  import act_pkg::*;
;
  logic               clk, rstn, wr, rd, pw, vwr, cb, rdv, hp, ob;
  logic        [7:0]  addr, wd, vv, rdata, vol, pt;
  logic        [3:0]  gt;
  logic signed [4:0]  gs;
  logic signed [23:0] a, b, sum;
  act_dsp_t           dsp;
  int                 n_mismatch, checks_done;

  act_config i_act_config (
    .i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_rd_valid(rdv), .i_adc_powered(pw),
    .i_volume_wr(vwr), .i_volume_value(vv), .o_digital_volume(vol),
    .o_fourth_channel_gain_trim(gt), .o_gain_trim_steps(gs),
    .o_fourth_channel_phase_trim(pt), .i_ch4_bit(cb), .o_ch4_bit(ob), .o_dsp(dsp),
    .o_hpf_programmable(hp), .i_first_channel(a), .i_second_channel(b),
    .o_sum_sample(sum)
  );

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= ad; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({31'h0, rdv}, 32'h1);
    chk({24'h0, rdata}, {24'h0, e});
  endtask

  task automatic test_reset;
    chk({24'h0, dsp}, 32'h01);
    chk({27'h0, gs}, 32'h00);
    chk({31'h0, hp}, 32'h0);
    rreg(ACT_OFS_GAIN_TRIM, 8'h80);
    rreg(ACT_OFS_PHASE_TRIM, 8'h00);
    rreg(ACT_OFS_DSP_FIRST, 8'h01);
    rreg(8'h50, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_gain;
    wreg(ACT_OFS_GAIN_TRIM, 8'h00);
    chk({27'h0, gs}, 32'h18);
    wreg(ACT_OFS_GAIN_TRIM, 8'hF0);
    chk({28'h0, gt}, 32'hF);
    chk({27'h0, gs}, 32'h07);
    rreg(ACT_OFS_GAIN_TRIM, 8'hF0);
    $display("test_gain done");
  endtask

  task automatic test_delay;
    int codes[4] = '{0, 1, 5, 255};
    foreach (codes[i])
    begin
      wreg(ACT_OFS_PHASE_TRIM, 8'(codes[i]));
      chk({24'h0, pt}, codes[i]);
      for (int k = 0; k < codes[i] + 40; k++)
      begin
        @(posedge clk);
        cb <= ^(k & 32'h25) ^ (k % 3 == 0);
        #1;
        if (k >= codes[i] + 2)
          chk({31'h0, ob}, ^((k - 1 - codes[i]) & 32'h25) ^ ((k - 1 - codes[i]) % 3 == 0));
      end
      rreg(ACT_OFS_PHASE_TRIM, 8'(codes[i]));
    end
    $display("test_delay done");
  endtask

  task automatic test_dsp;
    logic [7:0] w;
    for (int d = 0; d < 4; d++)
    begin
      w = {2'b00, 2'(d % 3), 2'(d == 1), 2'(d)};
      wreg(ACT_OFS_DSP_FIRST, w);
      repeat (2) @(posedge clk);
      #1;
      chk({24'h0, dsp}, {24'h0, w});
      chk({31'h0, hp}, (d == 0));
      chk({8'h0, sum}, (d == 1) ? 32'h08 : 32'hFFFFF0);
      rreg(ACT_OFS_DSP_FIRST, w);
    end
    $display("test_dsp done");
  endtask

  task automatic test_b2b;
    @(posedge clk);
    wr <= 1'b1; addr <= ACT_OFS_PHASE_TRIM; wd <= 8'h3C;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({31'h0, rdv}, 32'h1);
    chk({24'h0, rdata}, 32'h3C);
    $display("test_b2b done");
  endtask

  task automatic vol_wr(input logic [7:0] v, input logic [7:0] e);
    @(posedge clk);
    vwr <= 1'b1; vv <= v;
    @(posedge clk);
    vwr <= 1'b0;
    #1;
    chk({24'h0, vol}, {24'h0, e});
  endtask

  task automatic test_volume;
    pw <= 1'b1;
    wreg(ACT_OFS_DSP_FIRST, 8'h01);
    vol_wr(8'h5A, 8'h5A);
    wreg(ACT_OFS_DSP_FIRST, 8'h81);
    vol_wr(8'h33, 8'h5A);
    pw <= 1'b0;
    vol_wr(8'h77, 8'h77);
    $display("test_volume done");
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    n_mismatch = 0; checks_done = 0;
    rstn = 1'b0; wr = 1'b0; rd = 1'b0; pw = 1'b0; vwr = 1'b0; cb = 1'b0;
    addr = 8'h00; wd = 8'h00; vv = 8'h00;
    a = 24'hFFFFF0; b = 24'h000020;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1;
    test_reset();
    test_gain();
    test_delay();
    test_b2b();
    test_dsp();
    test_volume();
    test_done();
  end
endmodule
